// *** verilog/fdp_top.sv ***
// Purpose: Register side of the fractional divider phase and minimum-ratio control.
// Assumes: Same-clock byte register port; div_sync and frac_in come from on-clock logic.
// Notes: The fraction itself is not divided here; it is gated and passed to the modulator.
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "fdp_map.svh"
module fdp_top (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic [`FDP_ADDR_W-1:0]   addr,
  input  wire logic [`FDP_DATA_W-1:0]   wdata,
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  output logic      [`FDP_DATA_W-1:0]   rdata,
  input  wire logic                     div_sync,
  input  wire logic [`FDP_FRAC_W-1:0]   frac_in,
  output logic      [`FDP_FRAC_W-1:0]   frac_out,
  output logic                          sdm_enable,
  output logic                          divider_power_down,
  output logic                          divider_reset,
  output logic                          div_out
);
  fdp_div_if dif ();

  logic [7:0]               phase_lo_stage_reg;
  fdp_pkg::fdp_phase_t      phase_reg;
  logic                     phase_adjust_immediate_reg;
  logic                     phase_adjust_on_sync_reg;
  logic [`FDP_THR_W-1:0]    min_ratio_threshold_reg;
  fdp_pkg::fdp_ratio_t      ratio_reg;
  logic                     rst_bit_reg;
  logic                     pd_bit_reg;
  logic                     supported_reg;
  logic                     sync_reg;
  logic                     load_reg;
  fdp_pkg::fdp_phase_t      load_val_reg;
  logic                     hold_reg;
  logic [`FDP_DATA_W-1:0]   rdata_reg;
  logic [`FDP_FRAC_W-1:0]   frac_out_reg;
  logic                     sdm_enable_reg;

  logic                     wr_lo;
  logic                     wr_hi;
  logic                     adjust_ok;
  logic                     imm_start;
  logic                     sync_load;
  fdp_pkg::fdp_phase_t      phase_next;
  logic                     supported_next;

  function automatic logic ratio_ok(input fdp_pkg::fdp_ratio_t r,
                                    input logic [`FDP_THR_W-1:0] t);
    ratio_ok = (r >= {{(`FDP_RATIO_W-`FDP_THR_W){1'b0}}, t});
  endfunction

  function automatic logic is_wr(input logic w, input logic [`FDP_ADDR_W-1:0] a,
                                 input logic [`FDP_ADDR_W-1:0] off);
    is_wr = w && (a == off);
  endfunction

  assign wr_lo          = is_wr(wr_en, addr, `FDP_OFF_PHASE_LO);
  assign wr_hi          = is_wr(wr_en, addr, `FDP_OFF_PHASE_HI);
  assign supported_next = ratio_ok(ratio_reg, min_ratio_threshold_reg); // R17
  // Adjustments are refused in hardware too, so a careless write cannot disturb the output.
  assign adjust_ok      = supported_reg && !rst_bit_reg && !pd_bit_reg; // R12
  assign phase_next     = wr_hi ? {wdata[`FDP_HI_PH8_BIT], phase_lo_stage_reg} : phase_reg; // R8
  assign imm_start      = wr_hi && wdata[`FDP_HI_NOW_BIT] && !phase_adjust_immediate_reg
                          && adjust_ok; // R1
  assign sync_load      = div_sync && phase_adjust_on_sync_reg && adjust_ok; // R4

  // The low byte only stages; a half-written value never reaches the divider.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_lo_stage_reg <= 8'(`FDP_RST_PHASE); // R7
      phase_reg          <= `FDP_RST_PHASE; // R7
    end else begin
      if (wr_lo) begin
        phase_lo_stage_reg <= wdata; // R8
      end
      phase_reg <= phase_next; // R8
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_adjust_on_sync_reg <= 1'b0;
    end else if (wr_hi) begin
      phase_adjust_on_sync_reg <= wdata[`FDP_HI_SYNC_BIT]; // R4
    end
  end

  // A start is only accepted while the bit is clear, and it wins over a done in the same cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_adjust_immediate_reg <= 1'b0;
    end else if (imm_start) begin
      phase_adjust_immediate_reg <= 1'b1; // R1
    end else if (dif.done) begin
      phase_adjust_immediate_reg <= 1'b0; // R2
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      load_reg     <= 1'b0;
      load_val_reg <= `FDP_RST_PHASE;
      sync_reg     <= 1'b0;
    end else begin
      load_reg     <= imm_start || sync_load; // R1 R4
      load_val_reg <= phase_next; // R5
      sync_reg     <= div_sync;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      min_ratio_threshold_reg <= `FDP_RST_THR; // R10
      ratio_reg               <= `FDP_RST_RATIO; // R14
      rst_bit_reg             <= 1'b0;
      pd_bit_reg              <= 1'b0;
    end else if (wr_en) begin
      unique case (addr)
        `FDP_OFF_MIN_RATIO: min_ratio_threshold_reg <= wdata[`FDP_THR_W-1:0]; // R10
        `FDP_OFF_INT0:      ratio_reg[7:0]          <= wdata; // R14
        `FDP_OFF_INT1:      ratio_reg[15:8]         <= wdata;
        `FDP_OFF_INT2:      ratio_reg[23:16]        <= wdata;
        `FDP_OFF_INT3:      ratio_reg[24]           <= wdata[0];
        `FDP_OFF_CTRL: begin
          rst_bit_reg <= wdata[`FDP_CTRL_RST_BIT]; // R15
          pd_bit_reg  <= wdata[`FDP_CTRL_PD_BIT]; // R16
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      supported_reg  <= 1'b1;
      sdm_enable_reg <= 1'b0;
      frac_out_reg   <= '0;
      hold_reg       <= 1'b1;
    end else begin
      supported_reg  <= supported_next; // R17
      sdm_enable_reg <= supported_reg && !rst_bit_reg && !pd_bit_reg; // R11
      frac_out_reg   <= supported_reg ? frac_in : '0; // R11
      hold_reg       <= rst_bit_reg || pd_bit_reg; // R15 R16
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= '0;
    end else if (rd_en) begin
      unique case (addr)
        `FDP_OFF_PHASE_LO:  rdata_reg <= phase_reg[7:0];
        `FDP_OFF_PHASE_HI:  rdata_reg <= {phase_adjust_immediate_reg, phase_adjust_on_sync_reg,
                                          5'h00, phase_reg[8]};
        `FDP_OFF_MIN_RATIO: rdata_reg <= {2'h0, min_ratio_threshold_reg};
        `FDP_OFF_INT0:      rdata_reg <= ratio_reg[7:0];
        `FDP_OFF_INT1:      rdata_reg <= ratio_reg[15:8];
        `FDP_OFF_INT2:      rdata_reg <= ratio_reg[23:16];
        `FDP_OFF_INT3:      rdata_reg <= {7'h00, ratio_reg[24]};
        `FDP_OFF_CTRL:      rdata_reg <= {6'h00, pd_bit_reg, rst_bit_reg};
        `FDP_OFF_STATUS:    rdata_reg <= {6'h00, dif.busy, supported_reg};
        default:            rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  assign dif.ratio    = ratio_reg;
  assign dif.hold     = hold_reg;
  assign dif.sync     = sync_reg;
  assign dif.load     = load_reg;
  assign dif.load_val = load_val_reg;

  fdp_divider u_div (
    .clk  (clk),
    .rstn (rstn),
    .bus  (dif.div)
  );

  assign rdata              = rdata_reg;
  assign frac_out           = frac_out_reg;
  assign sdm_enable         = sdm_enable_reg;
  assign divider_power_down = pd_bit_reg;
  assign divider_reset      = rst_bit_reg;
  assign div_out            = dif.div_out;

  imm_launch_a: assert property (@(posedge clk) disable iff (!rstn) // R1
    wr_hi && wdata[`FDP_HI_NOW_BIT] && !phase_adjust_immediate_reg && adjust_ok
    |=> load_reg && phase_adjust_immediate_reg && load_val_reg == $past(phase_next))
    else $error("Immediate trigger did not launch.");
  imm_clear_a: assert property (@(posedge clk) disable iff (!rstn) // R2
    phase_adjust_immediate_reg && dif.done |=> !phase_adjust_immediate_reg)
    else $error("Immediate trigger not cleared on done.");
  imm_refuse_a: assert property (@(posedge clk) disable iff (!rstn) // R12
    !adjust_ok && !phase_adjust_immediate_reg |=> !phase_adjust_immediate_reg && !load_reg)
    else $error("Adjustment accepted while unsupported.");
  sync_apply_a: assert property (@(posedge clk) disable iff (!rstn) // R4
    div_sync && phase_adjust_on_sync_reg && adjust_ok |=> load_reg && sync_reg)
    else $error("Sync did not apply phase.");
  lo_atomic_a: assert property (@(posedge clk) disable iff (!rstn) // R8
    !wr_hi |=> $stable(phase_reg))
    else $error("Phase changed without upper byte write.");
  support_cmp_a: assert property (@(posedge clk) disable iff (!rstn) // R17
    ##1 supported_reg == ($past(ratio_reg) >= {19'h00000, $past(min_ratio_threshold_reg)}))
    else $error("Support flag does not follow compare.");
  sdm_gate_a: assert property (@(posedge clk) disable iff (!rstn) // R11
    !supported_reg |=> !sdm_enable_reg && frac_out_reg == '0)
    else $error("Modulator left on below threshold.");
  ctrl_hold_a: assert property (@(posedge clk) disable iff (!rstn) // R15
    wr_en && addr == `FDP_OFF_CTRL && wdata[`FDP_CTRL_RST_BIT] |=> ##1 hold_reg ##2 !div_out)
    else $error("Divider reset did not hold divider.");
  read_one_a: assert property (@(posedge clk) disable iff (!rstn)
    !rd_en |=> rdata_reg == '0)
    else $error("Read data outside its cycle.");
  imm_cov_c: cover property (@(posedge clk) disable iff (!rstn)
    imm_start ##[1:600] !phase_adjust_immediate_reg);
  sync_cov_c: cover property (@(posedge clk) disable iff (!rstn) sync_load);
  unsup_cov_c: cover property (@(posedge clk) disable iff (!rstn)
    !supported_reg && wr_hi && wdata[`FDP_HI_NOW_BIT]);
endmodule

// *** include/fdp_map.svh ***
// Purpose: Offsets, field positions, reset values and widths of the phase control block.
// Assumes: Byte-wide register port, one register per byte address.
// Notes: Included by the package and by both design modules.
//
// Notes on behaviour
// R1: A 0-to-1 write of the immediate trigger applies the programmed phase offset.
// R2: Hardware clears the immediate trigger once the started adjustment has finished.
// R3: Software sets no trigger while power-down, reset, or ratio below threshold.
// R4: With the on-sync bit set, every divider synchronisation applies the offset.
// R5: The nine-bit phase is two's complement; positive lags, negative leads.
// R6: Each phase unit moves the divider output by one VCO clock period.
// R7: Phase resets to zero; zero offset leaves the output at its natural alignment.
// R8: Phase is committed only on the upper byte write, then applied per triggers.
// R9: Software programs no phase while the ratio is below the threshold.
// R10: Six-bit minimum ratio threshold, reset 0x31, gates modulation and phase.
// R11: Below threshold the modulator is off and the fraction is forced to zero.
// R12: Below threshold no phase adjustment reaches the divider output.
// R13: Software leaves the threshold alone in normal operation; debug only.
// R14: The integer ratio is 25 bits, resets to 100, and is compared to threshold.
// R15: Divider reset bit at one holds the divider in reset, zero releases it.
// R16: Power-down bit at one powers the divider down, zero powers it up.
// R17: Ratio and threshold compare unsigned, continuously, following either change.
`ifndef FDP_MAP_SVH
`define FDP_MAP_SVH

`define FDP_ADDR_W        8
`define FDP_DATA_W        8
`define FDP_PHASE_W       9
`define FDP_RATIO_W       25
`define FDP_THR_W         6
`define FDP_FRAC_W        34
`define FDP_CNT_W         26

`define FDP_OFF_PHASE_LO  8'h00
`define FDP_OFF_PHASE_HI  8'h01
`define FDP_OFF_MIN_RATIO 8'h02
`define FDP_OFF_INT0      8'h04
`define FDP_OFF_INT1      8'h05
`define FDP_OFF_INT2      8'h06
`define FDP_OFF_INT3      8'h07
`define FDP_OFF_CTRL      8'h08
`define FDP_OFF_STATUS    8'h09

`define FDP_HI_NOW_BIT    7
`define FDP_HI_SYNC_BIT   6
`define FDP_HI_PH8_BIT    0
`define FDP_CTRL_RST_BIT  0
`define FDP_CTRL_PD_BIT   1
`define FDP_ST_SUPP_BIT   0
`define FDP_ST_BUSY_BIT   1

`define FDP_RST_PHASE     9'h000
`define FDP_RST_THR       6'h31
`define FDP_RST_RATIO     25'h0000064
`define FDP_MIN_PERIOD    26'h0000002

`endif

// *** include/fdp_pkg.sv ***
// Purpose: Types shared by the phase control block.
// Assumes: fdp_map.svh holds all numeric constants.
// Notes: Nothing here is imported; users write fdp_pkg::name.
`include "fdp_map.svh"
package fdp_pkg;
  typedef logic signed [`FDP_PHASE_W-1:0] fdp_phase_t;
  typedef logic        [`FDP_RATIO_W-1:0] fdp_ratio_t;
  typedef logic        [`FDP_CNT_W-1:0]   fdp_cnt_t;
  typedef enum logic [0:0] {FDP_HOLD, FDP_RUN} fdp_div_state_t;
endpackage

// *** include/fdp_div_if.sv ***
// Purpose: Carrier between the register side and the divider core.
// Assumes: Both ends run on the same clock.
// Notes: All signals but busy are driven from flip-flops at their source; busy decodes rem_reg.
`timescale 1ns/1ns
interface fdp_div_if;
  fdp_pkg::fdp_ratio_t ratio;
  logic                hold;
  logic                sync;
  logic                load;
  fdp_pkg::fdp_phase_t load_val;
  logic                busy;
  logic                done;
  logic                div_out;
  modport ctl (output ratio, output hold, output sync, output load, output load_val,
               input busy, input done, input div_out);
  modport div (input ratio, input hold, input sync, input load, input load_val,
               output busy, output done, output div_out);
endinterface

// *** verilog/fdp_divider.sv ***
// Purpose: Integer divider on the VCO clock with signed phase slewing.
// Assumes: clk is the VCO clock, so one cycle is one VCO period.
// Notes: A lead larger than one period is absorbed over several periods.
`timescale 1ns/1ns
`include "fdp_map.svh"
module fdp_divider (
  input wire logic clk,
  input wire logic rstn,
  fdp_div_if.div   bus
);
  fdp_pkg::fdp_div_state_t state_reg;
  fdp_pkg::fdp_cnt_t       count_reg;
  fdp_pkg::fdp_cnt_t       period_reg;
  logic signed [9:0]       rem_reg;
  logic                    out_reg;
  logic                    done_reg;
  fdp_pkg::fdp_cnt_t       eff;
  logic signed [9:0]       step;
  logic                    wrap;

  // Ratios below two cannot form a clock; they run at the smallest period.
  function automatic fdp_pkg::fdp_cnt_t eff_ratio(input fdp_pkg::fdp_ratio_t r);
    fdp_pkg::fdp_cnt_t w;
    w = {1'b0, r};
    eff_ratio = (w < `FDP_MIN_PERIOD) ? `FDP_MIN_PERIOD : w;
  endfunction

  // A lead may shorten one period to no less than the smallest period.
  function automatic logic signed [9:0] slew_step(input logic signed [9:0] rem,
                                                  input fdp_pkg::fdp_cnt_t e);
    logic signed [27:0] lim;
    lim = 28'sd2 - $signed({2'b00, e});
    if (rem >= 10'sd0) begin
      slew_step = rem;
    end else if ($signed({{18{rem[9]}}, rem}) < lim) begin
      slew_step = lim[9:0];
    end else begin
      slew_step = rem;
    end
  endfunction

  assign eff  = eff_ratio(bus.ratio);
  assign step = slew_step(rem_reg, eff);
  assign wrap = (count_reg == period_reg - 26'h0000001);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= fdp_pkg::FDP_HOLD;
    end else begin
      state_reg <= bus.hold ? fdp_pkg::FDP_HOLD : fdp_pkg::FDP_RUN;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg  <= '0;
      period_reg <= `FDP_MIN_PERIOD;
      rem_reg    <= 10'sd0;
      done_reg   <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        fdp_pkg::FDP_HOLD: begin
          count_reg  <= '0;
          period_reg <= eff;
          rem_reg    <= 10'sd0;
          // A hold that cuts a slew short still ends it, or the trigger bit would stick.
          done_reg   <= bus.load || (rem_reg != 10'sd0); // R2
        end
        fdp_pkg::FDP_RUN: begin
          if (bus.sync) begin
            count_reg  <= '0;
            period_reg <= eff;
          end else if (wrap) begin
            count_reg  <= '0;
            period_reg <= fdp_pkg::fdp_cnt_t'($signed({1'b0, eff}) + step); // R6
          end else begin
            count_reg <= count_reg + 26'h0000001;
          end
          if (bus.load) begin
            rem_reg  <= {bus.load_val[8], bus.load_val}; // R5
            done_reg <= (bus.load_val == 9'sd0); // R7
          end else if (wrap && !bus.sync && rem_reg != 10'sd0) begin
            rem_reg  <= rem_reg - step;
            done_reg <= (rem_reg == step); // R2
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= (state_reg == fdp_pkg::FDP_RUN) && (count_reg < {1'b0, period_reg[25:1]});
    end
  end

  assign bus.div_out = out_reg;
  assign bus.busy    = (rem_reg != 10'sd0);
  assign bus.done    = done_reg;

  hold_quiet_a: assert property (@(posedge clk) disable iff (!rstn) // R15
    bus.hold |-> ##2 (count_reg == '0) && !out_reg)
    else $error("Divider runs while held.");
  lag_period_a: assert property (@(posedge clk) disable iff (!rstn) // R6
    (state_reg == fdp_pkg::FDP_RUN) && wrap && !bus.sync && !bus.load && rem_reg > 10'sd0
    |=> period_reg == $past(eff) + fdp_pkg::fdp_cnt_t'($past(rem_reg)))
    else $error("Lag not added to one period.");
  slew_end_a: assert property (@(posedge clk) disable iff (!rstn) // R2
    $fell(bus.busy) && !$past(bus.load) |-> done_reg)
    else $error("Slew ended without done.");
  slew_cov_c: cover property (@(posedge clk) disable iff (!rstn) rem_reg < -10'sd60);
endmodule

// *** test/fdp_top_tb.sv ***
// Purpose: Self-checking bench for the phase and minimum-ratio control block.
// Assumes: Register map and constants of fdp_map.svh; clk is also the VCO clock.
// Notes: Phase steps are judged by summing whole divider periods between rises.
`timescale 1ns/1ns
`include "fdp_map.svh"
module fdp_top_tb;
  logic                   clk;
  logic                   rstn;
  logic [`FDP_ADDR_W-1:0] addr;
  logic [`FDP_DATA_W-1:0] wdata;
  logic                   wr_en;
  logic                   rd_en;
  logic [`FDP_DATA_W-1:0] rdata;
  logic                   div_sync;
  logic [`FDP_FRAC_W-1:0] frac_in;
  logic [`FDP_FRAC_W-1:0] frac_out;
  logic                   sdm_enable;
  logic                   divider_power_down;
  logic                   divider_reset;
  logic                   div_out;
  logic                   div_prev = 1'b0;
  int                     error_cnt = 0;
  int                     comparisons = 0;
  int                     cyc = 0;
  int                     rise_cnt = 0;
  int                     last_rise = 0;
  int                     t0;
  int                     t1;
  int                     t2;

  fdp_top u_fdp_top (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .div_sync(div_sync), .frac_in(frac_in),
    .frac_out(frac_out), .sdm_enable(sdm_enable), .divider_power_down(divider_power_down),
    .divider_reset(divider_reset), .div_out(div_out));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Rise times are kept in cycles so period sums need no rounding.
  always @(posedge clk) begin
    cyc      <= cyc + 1;
    div_prev <= div_out;
    if (div_out === 1'b1 && div_prev === 1'b0) begin
      rise_cnt  <= rise_cnt + 1;
      last_rise <= cyc;
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task automatic wait_cnt(input int target);
    int i;
    for (i = 0; i < 1000 && rise_cnt < target; i++) @(negedge clk);
    if (rise_cnt < target) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, rise_cnt, target);
      finish_test();
    end
  endtask

  // The window starts at the rise before the trigger, so a delayed wrap lands inside it.
  task automatic trig_measure(input logic [8:0] ph, input logic ok, input int n,
                              input int exp);
    int ts;
    int r0;
    reg_wr(`FDP_OFF_PHASE_LO, ph[7:0]);
    // Leave the write edge first, so a rise counted there cannot carry the old ratio.
    @(negedge clk);
    wait_cnt(rise_cnt + 1);
    ts = last_rise;
    r0 = rise_cnt;
    reg_wr(`FDP_OFF_PHASE_HI, {1'b1, 6'h00, ph[8]});
    if (ph != 9'h000) begin
      rd_chk(`FDP_OFF_PHASE_HI, {ok, 6'h00, ph[8]});
      rd_chk(`FDP_OFF_STATUS, {6'h00, ok, ok});
    end
    wait_cnt(r0 + n);
    check(last_rise - ts, exp);
    rd_chk(`FDP_OFF_PHASE_HI, {7'h00, ph[8]});
    $display("test trigger phase=%h done", ph);
  endtask

  task automatic sync_measure(output int t);
    int ts;
    int r0;
    wait_cnt(rise_cnt + 1);
    repeat (3) @(posedge clk);
    div_sync <= 1'b1;
    ts = cyc;
    r0 = rise_cnt;
    @(posedge clk);
    div_sync <= 1'b0;
    wait_cnt(r0 + 3);
    t = last_rise - ts;
  endtask

  logic [7:0] rst_addr [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                                8'h08, 8'h09};
  logic [7:0] rst_val  [10] = '{8'h00, 8'h00, 8'h31, 8'h00, 8'h64, 8'h00, 8'h00, 8'h00,
                                8'h00, 8'h01};

  initial begin
    rstn     = 1'b0;
    addr     = 8'h00;
    wdata    = 8'h00;
    wr_en    = 1'b0;
    rd_en    = 1'b0;
    div_sync = 1'b0;
    frac_in  = 34'h2AAAA5555;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 10; i++) rd_chk(rst_addr[i], rst_val[i]);
    check(sdm_enable, 1'b1);
    check(frac_out, frac_in);
    $display("test reset_values done");

    reg_wr(`FDP_OFF_INT0, 8'h30);
    rd_chk(`FDP_OFF_STATUS, 8'h00);
    check(sdm_enable, 1'b0);
    check(frac_out, 34'h000000000);
    reg_wr(`FDP_OFF_INT0, 8'h31);
    frac_in <= 34'h155550001;
    rd_chk(`FDP_OFF_STATUS, 8'h01);
    check(frac_out, 34'h155550001);
    reg_wr(`FDP_OFF_MIN_RATIO, 8'hFF);
    rd_chk(`FDP_OFF_MIN_RATIO, 8'h3F);
    rd_chk(`FDP_OFF_STATUS, 8'h00);
    reg_wr(`FDP_OFF_INT3, 8'hFF);
    rd_chk(`FDP_OFF_INT3, 8'h01);
    rd_chk(`FDP_OFF_STATUS, 8'h01);
    reg_wr(`FDP_OFF_INT3, 8'h00);
    reg_wr(`FDP_OFF_MIN_RATIO, 8'h31);
    reg_wr(8'h03, 8'hFF);
    rd_chk(8'h03, 8'h00);
    $display("test threshold done");

    reg_wr(`FDP_OFF_PHASE_HI, 8'h3E);
    rd_chk(`FDP_OFF_PHASE_HI, 8'h00);
    reg_wr(`FDP_OFF_PHASE_LO, 8'h05);
    rd_chk(`FDP_OFF_PHASE_LO, 8'h00);
    reg_wr(`FDP_OFF_PHASE_HI, 8'h00);
    rd_chk(`FDP_OFF_PHASE_LO, 8'h05);
    $display("test phase_commit done");

    reg_wr(`FDP_OFF_INT0, 8'h32);
    trig_measure(9'h003, 1'b1, 4, 203);
    trig_measure(9'h1FD, 1'b1, 4, 197);
    trig_measure(9'h000, 1'b1, 4, 200);
    trig_measure(9'h0FF, 1'b1, 4, 455);
    trig_measure(9'h100, 1'b1, 8, 144);
    reg_wr(`FDP_OFF_INT0, 8'h30);
    trig_measure(9'h003, 1'b0, 4, 192);
    reg_wr(`FDP_OFF_INT0, 8'h32);

    reg_wr(`FDP_OFF_PHASE_LO, 8'h02);
    reg_wr(`FDP_OFF_PHASE_HI, 8'h00);
    sync_measure(t0);
    reg_wr(`FDP_OFF_PHASE_LO, 8'h02);
    reg_wr(`FDP_OFF_PHASE_HI, 8'h40);
    rd_chk(`FDP_OFF_PHASE_HI, 8'h40);
    sync_measure(t1);
    sync_measure(t2);
    check(t1 - t0, 2);
    check(t2 - t0, 2);
    reg_wr(`FDP_OFF_PHASE_HI, 8'h00);
    $display("test on_sync done");

    // A refused trigger must leave the bit at zero rather than linger as a pending request.
    reg_wr(`FDP_OFF_CTRL, 8'h01);
    @(posedge clk);
    #1;
    check(divider_reset, 1'b1);
    check(sdm_enable, 1'b0);
    reg_wr(`FDP_OFF_PHASE_HI, 8'h80);
    rd_chk(`FDP_OFF_PHASE_HI, 8'h00);
    reg_wr(`FDP_OFF_CTRL, 8'h02);
    @(posedge clk);
    #1;
    check(divider_power_down, 1'b1);
    check(divider_reset, 1'b0);
    reg_wr(`FDP_OFF_PHASE_HI, 8'h80);
    rd_chk(`FDP_OFF_PHASE_HI, 8'h00);
    reg_wr(`FDP_OFF_CTRL, 8'h00);
    @(posedge clk);
    #1;
    check(divider_power_down, 1'b0);
    check(sdm_enable, 1'b1);
    $display("test ctrl_gating done");
    finish_test();
  end
endmodule
